// ==== ascs_pkg.sv ====
package ascs_pkg;

  // ----------------------------------------------------------------
  // control byte layout
  // ----------------------------------------------------------------
  localparam int CTRL_BITS = 8;
  localparam int RES_BITS = 12;
  localparam int START_POS = 7;
  localparam int SEL_MSB_POS = 6;
  localparam int SEL_MID_POS = 5;
  localparam int SEL_LSB_POS = 4;
  localparam int POL_POS = 3;
  localparam int CFG_POS = 2;
  localparam int MODE_HI_POS = 1;
  localparam int MODE_LO_POS = 0;

  // mode field codes
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT_CLK = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK = 2'h3;

  // all-ones byte: single-ended unipolar, input seven, external clock
  localparam logic [7:0] CTRL_ALL_ONES = 8'hFF;

  // ----------------------------------------------------------------
  // sequencing counts, in shift clock edges
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_SEL_DONE = 4'h4;
  localparam logic [3:0] BITS_TRACK = 4'h5;
  localparam logic [3:0] BITS_CFG_DONE = 4'h6;
  localparam logic [3:0] BITS_LAST_M1 = 4'h7;
  localparam logic [3:0] BITS_FULL = 4'h8;
  localparam logic [3:0] FALLS_DECIDE = 4'hC;
  localparam logic [3:0] FALLS_CONV_M1 = 4'hE;

  localparam logic [11:0] TRIAL_MSB = 12'h800;

  // ----------------------------------------------------------------
  // link state, gray along idle -> control -> convert; convert -> idle flips both bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASCS_IDLE = 2'h0,
    ASCS_CTRL = 2'h1,
    ASCS_CONV = 2'h3
  } ascs_link_state_t;

endpackage

// ==== ascs_sync.sv ====
`timescale 1ns/1ps
module ascs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // first stage feeds only the second stage
  always_comb begin
    next_meta = resetn_i ? async_i : RESET_VAL;
    next_sync = resetn_i ? meta : RESET_VAL;
  end

  always_ff @(posedge clk_i) begin
    meta <= next_meta;
    sync_o <= next_sync;
  end
endmodule

// ==== ascs_sequencer.sv ====
`timescale 1ns/1ps
// Functional notes
// (RULE_01) while select is low, each shift clock rise shifts in a command bit; the code ignores rises during conversion
// (RULE_02) first one after select falls is control byte msb; seven follow
// (RULE_03) zeros before the start bit are ignored and change nothing
// (RULE_04) acquisition spans three clocks, ending the fall after bit eight
// (RULE_05) tracking begins on the fall after the fifth control bit
// (RULE_06) hold begins on the fall after the eighth bit; conversion starts
// (RULE_07) single-ended: positive node to chosen input, negative to ground
// (RULE_08) differential: nodes from fixed pairs 0/1, 2/3, 4/5, 6/7
// (RULE_09) after conversion the hold capacitor tracks the input again
// (RULE_10) byte FF: single-ended unipolar, input seven, external clock
// (RULE_11) external mode: strobe high one clock period before result msb
// (RULE_12) external mode conversion takes fifteen shift clocks in total
// (RULE_13) strobe and serial output change only on shift clock falls; the code also clears both at once on a select rise
// (RULE_14) host uses clock idle low, data captured on rising edges
// (RULE_15) host may use three byte transfers: control then two zero bytes
// (RULE_16) host sends a fresh control byte before every conversion
// (RULE_17) byte: start, three select, polarity, config, two-bit mode
// (RULE_18) two lowest bits choose clock mode and power-down behaviour
// (RULE_19) result msb first; unipolar binary, bipolar two's complement
// (RULE_20) serial output is released whenever select is high
// (RULE_21) select rise drops partial byte and re-arms start detection
module ascs_sequencer
  import ascs_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic cmd_i,
  input wire logic compare_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_o,
  output logic track_o,
  output logic hold_o,
  output logic [ascs_pkg::RES_BITS-1:0] dac_code_o,
  output logic [2:0] pos_sel_o,
  output logic [2:0] neg_sel_o,
  output logic neg_to_ground_o,
  output logic polarity_select_o,
  output logic input_config_select_o,
  output logic ext_clock_mode_o,
  output logic full_power_down_o,
  output logic fast_power_down_o,
  output logic conv_busy_o,
  output logic [ascs_pkg::RES_BITS-1:0] result_o,
  output logic result_valid_o
);

  // ----------------------------------------------------------------
  // link side, rising edges: command capture
  // ----------------------------------------------------------------
  ascs_link_state_t state;
  ascs_link_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [CTRL_BITS-1:0] shreg;
  logic [CTRL_BITS-1:0] next_shreg;
  logic [CTRL_BITS-1:0] shifted;
  logic [2:0] next_pos_sel;
  logic [2:0] next_neg_sel;
  logic next_neg_to_ground;
  logic [CTRL_BITS-1:0] config_byte;
  logic [CTRL_BITS-1:0] next_config_byte;
  logic conv_tgl;
  logic next_conv_tgl;
  logic done;

  always_comb begin
    shifted = {shreg[CTRL_BITS-2:0], cmd_i};
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_pos_sel = pos_sel_o;
    next_neg_sel = neg_sel_o;
    next_neg_to_ground = neg_to_ground_o;
    next_config_byte = config_byte;
    next_conv_tgl = conv_tgl;
    unique case (state)
      ASCS_IDLE: begin
        if (cmd_i) begin // RULE_02
          next_state = ASCS_CTRL;
          next_bit_cnt = 4'h1;
          next_shreg = shifted; // RULE_01
        end // zeros leave everything untouched RULE_03
      end
      ASCS_CTRL: begin
        next_shreg = shifted; // RULE_01
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == BITS_SEL_DONE - 4'h1) begin
          // select field complete: table order is {mid, lsb, msb}
          next_pos_sel = {shifted[1], shifted[0], shifted[2]}; // RULE_07
        end
        if (bit_cnt == BITS_CFG_DONE - 4'h1) begin
          next_pos_sel = {shifted[3], shifted[2], shifted[4]};
          next_neg_to_ground = shifted[0]; // RULE_07
          next_neg_sel = {shifted[3], shifted[2], ~shifted[4]}; // RULE_08
        end
        if (bit_cnt == BITS_LAST_M1) begin
          next_state = ASCS_CONV;
          next_config_byte = shifted; // RULE_17
          next_conv_tgl = ~conv_tgl;
        end
      end
      ASCS_CONV: begin
        // host clocks zeros meanwhile; a new byte waits for the end
        if (done) begin
          next_state = ASCS_IDLE; // RULE_16
          next_bit_cnt = 4'h0;
        end
      end
      default: begin
        next_state = ASCS_IDLE;
        next_bit_cnt = 4'h0;
      end
    endcase
  end

  // select high clears the frame at once; the clock may be stopped
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin // RULE_21
      state <= ASCS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      pos_sel_o <= 3'h0;
      neg_sel_o <= 3'h0;
      neg_to_ground_o <= 1'b1;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      pos_sel_o <= next_pos_sel;
      neg_sel_o <= next_neg_sel;
      neg_to_ground_o <= next_neg_to_ground;
    end
  end

  // survives select so the other domain reads a stable copy
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_byte <= 8'h00;
      conv_tgl <= 1'b0;
    end else begin
      config_byte <= next_config_byte;
      conv_tgl <= next_conv_tgl;
    end
  end

  // ----------------------------------------------------------------
  // link side, falling edges: track/hold and approximation
  // ----------------------------------------------------------------
  logic active;
  logic next_active;
  logic next_done;
  logic next_track;
  logic next_hold;
  logic next_strobe;
  logic next_dout;
  logic [3:0] fall_cnt;
  logic [3:0] next_fall_cnt;
  logic [RES_BITS-1:0] sar;
  logic [RES_BITS-1:0] next_sar;
  logic [RES_BITS-1:0] next_dac;
  logic [RES_BITS-1:0] result_link;
  logic [RES_BITS-1:0] next_result_link;
  logic done_tgl;
  logic next_done_tgl;
  logic ext_mode_link;
  logic bipolar_link;
  logic [3:0] bit_idx;
  logic decision;

  always_comb begin
    ext_mode_link = (config_byte[MODE_HI_POS:MODE_LO_POS] == MODE_EXT_CLK);
    bipolar_link = ~config_byte[POL_POS];
    bit_idx = 4'hB - fall_cnt;
    decision = compare_i;
    next_active = active;
    next_done = done;
    next_track = track_o;
    next_hold = hold_o;
    next_strobe = 1'b0; // RULE_13
    next_dout = 1'b0;
    next_fall_cnt = fall_cnt;
    next_sar = sar;
    next_dac = dac_code_o;
    next_result_link = result_link;
    next_done_tgl = done_tgl;
    if (state != ASCS_CONV) begin
      next_done = 1'b0;
    end
    if (state == ASCS_CTRL && bit_cnt == BITS_TRACK) begin
      next_track = 1'b1; // RULE_05
    end
    if (state == ASCS_CONV && !active && !done) begin
      // end of acquisition: switch opens RULE_04
      next_track = 1'b0;
      next_hold = 1'b1; // RULE_06
      next_active = 1'b1;
      next_fall_cnt = 4'h0;
      next_sar = 12'h000;
      next_dac = TRIAL_MSB;
      next_strobe = ext_mode_link; // RULE_11
    end else if (active) begin
      next_fall_cnt = fall_cnt + 4'h1; // RULE_12
      if (fall_cnt < FALLS_DECIDE) begin
        next_sar = sar | (decision ? dac_code_o : 12'h000);
        // bipolar: offset code with flipped msb is two's complement
        next_dout = decision ^ (bipolar_link && fall_cnt == 4'h0); // RULE_19
        next_dac = next_sar;
        if (fall_cnt < FALLS_DECIDE - 4'h1) begin
          next_dac = next_sar | (TRIAL_MSB >> (4'hB - bit_idx + 4'h1));
        end
      end
      if (fall_cnt == FALLS_CONV_M1) begin
        next_active = 1'b0;
        next_done = 1'b1;
        next_hold = 1'b0;
        next_track = 1'b1; // RULE_09
        next_result_link = {sar[RES_BITS-1] ^ bipolar_link,
                            sar[RES_BITS-2:0]}; // RULE_19
        next_done_tgl = ~done_tgl;
      end
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin // RULE_21
      active <= 1'b0;
      done <= 1'b0;
      track_o <= 1'b0;
      hold_o <= 1'b0;
      conversion_strobe_o <= 1'b0;
      dout_o <= 1'b0;
      fall_cnt <= 4'h0;
      sar <= 12'h000;
      dac_code_o <= 12'h000;
    end else begin
      active <= next_active;
      done <= next_done;
      track_o <= next_track;
      hold_o <= next_hold;
      conversion_strobe_o <= next_strobe; // RULE_13
      dout_o <= next_dout; // RULE_13
      fall_cnt <= next_fall_cnt;
      sar <= next_sar;
      dac_code_o <= next_dac;
    end
  end

  always_ff @(negedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_link <= 12'h000;
      done_tgl <= 1'b0;
    end else begin
      result_link <= next_result_link;
      done_tgl <= next_done_tgl;
    end
  end

  // ----------------------------------------------------------------
  // system side: crossings
  // ----------------------------------------------------------------
  logic [2:0] sync_bus;
  logic cs_n_sync;
  logic conv_sync;
  logic done_sync;
  logic conv_seen;
  logic done_seen;
  logic next_conv_seen;
  logic next_done_seen;

  // words ride on toggles: word and toggle change on one edge; the word is stable before the synced toggle is seen
  ascs_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({cs_n_i, conv_tgl, done_tgl}),
    .sync_o(sync_bus)
  );

  assign cs_n_sync = sync_bus[2];
  assign conv_sync = sync_bus[1];
  assign done_sync = sync_bus[0];

  // ----------------------------------------------------------------
  // system side: status and mode outputs
  // ----------------------------------------------------------------
  logic next_dout_oe;
  logic next_strobe_oe;
  logic next_polarity;
  logic next_input_cfg;
  logic next_ext_mode;
  logic next_full_pd;
  logic next_fast_pd;
  logic next_busy;
  logic [RES_BITS-1:0] next_result;
  logic next_result_valid;
  logic [1:0] mode_field;

  always_comb begin
    mode_field = config_byte[MODE_HI_POS:MODE_LO_POS];
    next_conv_seen = conv_sync;
    next_done_seen = done_sync;
    next_polarity = polarity_select_o;
    next_input_cfg = input_config_select_o;
    next_ext_mode = ext_clock_mode_o;
    next_full_pd = full_power_down_o;
    next_fast_pd = fast_power_down_o;
    next_busy = conv_busy_o;
    next_result = result_o;
    next_result_valid = 1'b0;
    if (conv_sync != conv_seen) begin
      // an all-ones byte lands here as ext, unipolar, single, input 7
      next_polarity = config_byte[POL_POS]; // RULE_10
      next_input_cfg = config_byte[CFG_POS];
      next_ext_mode = (mode_field == MODE_EXT_CLK); // RULE_18
      next_full_pd = (mode_field == MODE_FULL_PD);
      next_fast_pd = (mode_field == MODE_FAST_PD);
      next_busy = 1'b1;
    end
    if (done_sync != done_seen) begin
      next_result = result_link;
      next_result_valid = 1'b1;
      next_busy = 1'b0;
    end else if (cs_n_sync) begin
      next_busy = 1'b0; // aborted frame
    end
    next_dout_oe = ~cs_n_sync; // RULE_20
    next_strobe_oe = ~cs_n_sync & next_ext_mode;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      conv_seen <= 1'b0;
      done_seen <= 1'b0;
      dout_oe_o <= 1'b0;
      conversion_strobe_oe_o <= 1'b0;
      polarity_select_o <= 1'b0;
      input_config_select_o <= 1'b0;
      ext_clock_mode_o <= 1'b0;
      full_power_down_o <= 1'b0;
      fast_power_down_o <= 1'b0;
      conv_busy_o <= 1'b0;
      result_o <= 12'h000;
      result_valid_o <= 1'b0;
    end else begin
      conv_seen <= next_conv_seen;
      done_seen <= next_done_seen;
      dout_oe_o <= next_dout_oe;
      conversion_strobe_oe_o <= next_strobe_oe;
      polarity_select_o <= next_polarity;
      input_config_select_o <= next_input_cfg;
      ext_clock_mode_o <= next_ext_mode;
      full_power_down_o <= next_full_pd;
      fast_power_down_o <= next_fast_pd;
      conv_busy_o <= next_busy;
      result_o <= next_result;
      result_valid_o <= next_result_valid;
    end
  end

endmodule

// ==== ascs_checker.sv ====
`timescale 1ns/1ps
module ascs_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic conversion_strobe_o,
  input wire logic track_o,
  input wire logic hold_o,
  input wire logic [2:0] pos_sel_o,
  input wire logic [2:0] neg_sel_o,
  input wire logic neg_to_ground_o,
  input wire logic ext_clock_mode_o,
  input wire logic full_power_down_o,
  input wire logic fast_power_down_o,
  input wire logic result_valid_o
);
  // ------
  // link side, sampled on shift clock rises
  // ------
  property p_acquire;
    @(posedge sclk_i) disable iff (cs_n_i)
    $rose(hold_o) |-> !track_o && $past(track_o, 3) && !$past(track_o, 4);
  endproperty
  a_acquire: assert property (p_acquire)
    else $error("acquisition not three clocks");
  property p_track_hold;
    @(posedge sclk_i) disable iff (cs_n_i)
    $rose(track_o) && !$past(hold_o) |-> ##3 $rose(hold_o);
  endproperty
  a_track_hold: assert property (p_track_hold)
    else $error("hold not three clocks after track");
  property p_hold_len;
    @(posedge sclk_i) disable iff (cs_n_i)
    $rose(hold_o) |-> hold_o [*8] ##1 hold_o [*7] ##1 !hold_o;
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("conversion not fifteen clocks");
  property p_retrack;
    @(posedge sclk_i) disable iff (cs_n_i)
    $fell(hold_o) |-> track_o;
  endproperty
  a_retrack: assert property (p_retrack)
    else $error("no tracking after conversion");
  property p_strobe;
    @(posedge sclk_i) disable iff (cs_n_i)
    $rose(conversion_strobe_o) |-> $rose(hold_o) ##1 !conversion_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe not one clock at hold");
  property p_diff_pair;
    @(posedge sclk_i) disable iff (cs_n_i)
    hold_o && !neg_to_ground_o |-> neg_sel_o == (pos_sel_o ^ 3'h1);
  endproperty
  a_diff_pair: assert property (p_diff_pair)
    else $error("differential pair wrong");
  // ------
  // system clock side; the hold and strobe covers sample on shift clock rises
  // ------
  property p_edges;
    @(posedge clk_i) disable iff (!resetn_i)
    !cs_n_i && $changed({dout_o, conversion_strobe_o}) |-> $fell(sclk_i);
  endproperty
  a_edges: assert property (p_edges)
    else $error("output moved off a falling edge");
  property p_oe_off;
    @(posedge clk_i) disable iff (!resetn_i)
    cs_n_i [*4] |-> !dout_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven while deselected");
  property p_oe_on;
    @(posedge clk_i) disable iff (!resetn_i)
    !cs_n_i [*4] |-> dout_oe_o;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output not driven while selected");
  property p_modes;
    @(posedge clk_i) disable iff (!resetn_i)
    $onehot0({ext_clock_mode_o, full_power_down_o, fast_power_down_o});
  endproperty
  a_modes: assert property (p_modes)
    else $error("mode flags overlap");
  c_hold: cover property (@(posedge sclk_i) $rose(hold_o));
  c_strobe: cover property (@(posedge sclk_i) $rose(conversion_strobe_o));
  c_valid: cover property (@(posedge clk_i) result_valid_o);
endmodule

bind ascs_sequencer ascs_checker i_ascs_checker (
  .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .dout_o(dout_o), .dout_oe_o(dout_oe_o), .track_o(track_o),
  .conversion_strobe_o(conversion_strobe_o), .hold_o(hold_o),
  .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
  .neg_to_ground_o(neg_to_ground_o), .ext_clock_mode_o(ext_clock_mode_o),
  .full_power_down_o(full_power_down_o),
  .fast_power_down_o(fast_power_down_o), .result_valid_o(result_valid_o)
);

// ==== ascs_host_model.sv ====
`timescale 1ns/1ps
module ascs_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic cmd_o,
  output logic compare_o,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  input wire logic [11:0] dac_code_i,
  input wire logic [11:0] target_i
);
  // comparator stand-in: keep the trial bit while input is at or above it
  assign compare_o = dac_code_i <= target_i;
  // a select rise right after start clears the frame logic, whatever
  // order the processes wake in at time zero
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    cmd_o = 1'b0;
    #1;
    cs_n_o = 1'b1;
  end
  task automatic open_frame();
    // off the system clock grid, so no link edge meets a clk edge
    #7.3;
    cs_n_o = 1'b0;
    #15;
  endtask
  task automatic close_frame();
    #15;
    cs_n_o = 1'b1;
    // no pull on the command line, so show the opposite of the last bit
    cmd_o = ~cmd_o;
  endtask
  // msb first; a result byte only completes with all eight clocks
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      #1;
      cmd_o = tx[7 - i];
      #14;
      sclk_o = 1'b1;
      rx = {rx[6:0], (dout_oe_i === 1'b1) ? dout_i : 1'bx};
      #15;
      sclk_o = 1'b0;
    end
  endtask
endmodule

// ==== ascs_sequencer_tb.sv ====
`timescale 1ns/1ps
module ascs_sequencer_tb;
  import ascs_pkg::*;
  logic clk, resetn, sclk, cs_n, cmd, compare, dout, dout_oe, strobe;
  logic strobe_oe, track, hold, neg_gnd, pol, cfg, ext, full_pd, fast_pd;
  logic busy, result_valid;
  logic [11:0] dac_code, result, target;
  logic [2:0] pos_sel, neg_sel;
  logic [7:0] rb1, rb2, rb3;
  int fails = 0, samples_checked = 0, cycles = 0, valid_seen = 0, v;
  int strobes = 0;

  ascs_sequencer i_ascs_sequencer (
    .clk_i(clk), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n),
    .cmd_i(cmd), .compare_i(compare), .dout_o(dout), .dout_oe_o(dout_oe),
    .conversion_strobe_o(strobe), .conversion_strobe_oe_o(strobe_oe),
    .track_o(track), .hold_o(hold), .dac_code_o(dac_code),
    .pos_sel_o(pos_sel), .neg_sel_o(neg_sel), .neg_to_ground_o(neg_gnd),
    .polarity_select_o(pol), .input_config_select_o(cfg),
    .ext_clock_mode_o(ext), .full_power_down_o(full_pd),
    .fast_power_down_o(fast_pd), .conv_busy_o(busy), .result_o(result),
    .result_valid_o(result_valid)
  );
  ascs_host_model i_ascs_host_model (
    .sclk_o(sclk), .cs_n_o(cs_n), .cmd_o(cmd), .compare_o(compare),
    .dout_i(dout), .dout_oe_i(dout_oe), .dac_code_i(dac_code),
    .target_i(target)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge sclk) if (strobe === 1'b1) strobes++;
  always @(posedge clk) begin
    cycles++;
    if (result_valid === 1'b1) valid_seen++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ------
  // one whole conversion frame, optionally led by a zero byte
  // ------
  task automatic convert(input logic [7:0] c, input logic [11:0] t,
                         input bit lead);
    logic [11:0] res;
    logic [2:0] pos;
    int v0, s0;
    target = t;
    v0 = valid_seen;
    s0 = strobes;
    res = c[POL_POS] ? t : t ^ 12'h800;
    pos = {c[SEL_MID_POS], c[SEL_LSB_POS], c[SEL_MSB_POS]};
    i_ascs_host_model.open_frame();
    if (lead) i_ascs_host_model.xfer(8'h00, 8, rb1);
    i_ascs_host_model.xfer(c, 8, rb1);
    i_ascs_host_model.xfer(8'h00, 8, rb2);
    i_ascs_host_model.xfer(8'h00, 8, rb3);
    check("pos_sel", 16'(pos), 16'(pos_sel));
    check("neg_gnd", 16'(c[CFG_POS]), 16'(neg_gnd));
    if (!c[CFG_POS]) check("neg_sel", 16'(pos ^ 3'h1), 16'(neg_sel));
    check("stb_oe", 16'(c[1:0] == MODE_EXT_CLK), 16'(strobe_oe));
    check("strobes", 16'(s0 + int'(c[1:0] == MODE_EXT_CLK)),
          16'(strobes));
    if (c[1:0] == MODE_EXT_CLK) begin
      check("rb2", {9'h000, res[11:5]}, 16'(rb2));
      check("rb3", {8'h00, res[4:0], 3'h0}, 16'(rb3));
    end
    i_ascs_host_model.close_frame();
    repeat (8) @(posedge clk);
    check("result", 16'(res), 16'(result));
    check("valid", 16'(v0 + 1), 16'(valid_seen));
    check("busy_done", 16'h0000, 16'(busy));
    check("modes", {11'h000, c[1:0] == MODE_EXT_CLK,
      c[1:0] == MODE_FAST_PD, c[1:0] == MODE_FULL_PD, c[POL_POS], c[CFG_POS]},
      {11'h000, ext, fast_pd, full_pd, pol, cfg});
  endtask

  initial begin
    resetn <= 1'b0;
    target = 12'h000;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check("oe_idle", 16'h0000, 16'(dout_oe));
    convert(CTRL_ALL_ONES, 12'hA5C, 1'b1);
    for (int k = 0; k < 8; k++) begin
      convert({1'b1, 3'(k), k[0], k[1], 2'(k) ^ {2{k[2]}}},
              12'h3C5 + 12'(k * 12'h12D), 1'b0);
    end
    // a select rise mid-byte must leave no trace in the next frame
    i_ascs_host_model.open_frame();
    i_ascs_host_model.xfer(8'hFF, 5, rb1);
    i_ascs_host_model.close_frame();
    convert(8'hC7, 12'h7FF, 1'b0);
    // select rise mid-conversion aborts with no result
    v = valid_seen;
    i_ascs_host_model.open_frame();
    i_ascs_host_model.xfer(8'hFF, 8, rb1);
    i_ascs_host_model.xfer(8'h00, 4, rb2);
    check("busy", 16'h0001, 16'(busy));
    i_ascs_host_model.close_frame();
    repeat (8) @(posedge clk);
    check("abort_valid", 16'(v), 16'(valid_seen));
    check("abort_busy", 16'h0000, 16'(busy));
    check("oe_off", 16'h0000, 16'(dout_oe));
    conclude();
  end
endmodule
